// ---- common/tlc_pkg.sv ----
package tlc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int SEC_MS        = 1000;
    localparam int PROBE_MS      = 100;
    localparam int NUM_DIGITS    = 4;

    // Register byte offsets
    localparam logic [4:0] ADDR_CMD    = 5'h00;
    localparam logic [4:0] ADDR_DIGIT  = 5'h04;
    localparam logic [4:0] ADDR_CONFIG = 5'h08;
    localparam logic [4:0] ADDR_TIMES  = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // Field positions
    localparam int TIMES_SLEEP_LSB = 16;
    localparam int ST_SLEEPING     = 0;
    localparam int ST_READING      = 1;
    localparam int ST_HOLD         = 2;
    localparam int ST_PEND_LSB     = 4;
    localparam int ST_DIG_LSB      = 8;
    localparam int ST_PIN_STAGED   = 12;

    // Reset values of the numeric settings
    localparam logic [13:0] RST_REREAD_MS = 14'h02BC;
    localparam logic [13:0] RST_SLEEP_S   = 14'h0005;

    typedef enum logic [7:0] {
        CMD_REPEAT_OFF  = 8'h01, CMD_REPEAT_ON   = 8'h02,
        CMD_AUTO_OFF    = 8'h03, CMD_AUTO_ON     = 8'h04,
        CMD_PRESENT     = 8'h05, CMD_HANDHELD    = 8'h06,
        CMD_SENS_HIGH   = 8'h07, CMD_SENS_NORMAL = 8'h08,
        CMD_SENS_LOW    = 8'h09, CMD_REREAD      = 8'h0A,
        CMD_END_LONG    = 8'h0B, CMD_END_NORMAL  = 8'h0C,
        CMD_END_SHORT   = 8'h0D, CMD_RTIME_AUTO  = 8'h0E,
        CMD_RTIME_FIXED = 8'h0F, CMD_SLEEP_DELAY = 8'h10,
        CMD_DET_AIM     = 8'h11, CMD_DET_WARM    = 8'h12,
        CMD_DET_UNLIT   = 8'h13, CMD_ILLUM_ON    = 8'h14,
        CMD_ILLUM_OFF   = 8'h15, CMD_ILLUM_ALT   = 8'h16,
        CMD_ILLUM_GLARE = 8'h17, CMD_ILLUM_STD   = 8'h18,
        CMD_ILLUM_LOW   = 8'h19, CMD_PIN_GOOD    = 8'h1A,
        CMD_PIN_EXT     = 8'h1B, CMD_SAVE        = 8'h1C,
        CMD_AIM_ON      = 8'h1D, CMD_AIM_OFF     = 8'h1E,
        CMD_AIM_HIGH    = 8'h1F, CMD_AIM_STD     = 8'h20,
        CMD_AIM_LOW     = 8'h21, CMD_TRIGGER     = 8'h22,
        CMD_CENTRAL_ON  = 8'h23, CMD_CENTRAL_OFF = 8'h24
    } tlc_cmd_type;

    typedef enum logic [1:0] {
        LVL_NORMAL = 2'h0, LVL_HIGH = 2'h1, LVL_LOW = 2'h2
    } tlc_lvl_type;

    typedef enum logic [1:0] {
        DET_AIM = 2'h0, DET_WARM = 2'h1, DET_UNLIT = 2'h2
    } tlc_det_type;

    typedef enum logic [1:0] {
        ILL_GLARE = 2'h0, ILL_ON = 2'h1, ILL_OFF = 2'h2, ILL_ALT = 2'h3
    } tlc_ill_type;

    typedef enum logic [1:0] {
        NUM_NONE = 2'h0, NUM_REREAD = 2'h1, NUM_SLEEP = 2'h2
    } tlc_num_type;

    typedef struct packed {
        logic        autoOn;
        logic        repeatOn;
        logic        handheld;
        tlc_lvl_type sens;
        tlc_lvl_type scanEnd;
        logic        readAuto;
        logic        central;
        tlc_det_type detSrc;
        tlc_ill_type illumMode;
        logic        illumLow;
        logic        pinExtLight;
        logic        aimOn;
        tlc_lvl_type aimLvl;
    } tlc_cfg_type;

    localparam tlc_cfg_type CFG_RESET = '{
        autoOn: 1'b0, repeatOn: 1'b0, handheld: 1'b0, sens: LVL_NORMAL,
        scanEnd: LVL_NORMAL, readAuto: 1'b0, central: 1'b0,
        detSrc: DET_AIM, illumMode: ILL_GLARE, illumLow: 1'b0,
        pinExtLight: 1'b0, aimOn: 1'b1, aimLvl: LVL_HIGH};

    typedef struct packed {
        logic        objectDetect;
        logic        readDone;
        logic        decodeValid;
        logic        decodeSame;
        logic        specular;
    } tlc_eng_type;

endpackage : tlc_pkg

// ---- design/tlc_core.sv ----
`timescale 1ns/1ps
// Behaviour
// - Reset leaves manual trigger mode with trigger repeat off.
// - Repeat restarts reads only in manual mode; repeat-off stops it.
// - Repeated reads follow read-done timing; central reading setting is only stored in cfg.
// - Auto trigger off by default; when on, detected objects start reads.
// - Auto sub-modes: presentation (default) or handheld, by command.
// - Detection sensitivity high, normal or low; normal by default.
// - Auto mode holds off identical data for a ms interval, default 700.
// - Different decoded data passes and restarts the hold-off.
// - Zero interval suppresses identical data indefinitely.
// - Scan end timing long, normal or short; normal by default.
// - Automatic read time lets the engine pick the duration.
// - Auto mode sleeps after set seconds without detection, default 5.
// - Asleep, probe periodically; wake on detection or trigger.
// - Zero sleep time never enters sleep.
// - Detection light: aiming (default), warm illumination or none.
// - Illumination on, off, alternating with memory, or glare guard.
// - Glare guard turns illumination off only on specular reflection.
// - Illumination brightness standard (default) or low.
// - Shared pin is good-read (default) or external light, never both.
// - New pin function applies only after the save command.
// - Aiming enabled by default; separate enable and disable commands.
// - Aiming brightness high (default), standard or low.
// - Reads start on trigger falling edge, trigger command or auto detection.
module tlc_core
    import tlc_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        trigger_in_n,
    input  wire tlc_eng_type eng,
    output tlc_cfg_type      cfg,
    output logic             readStart,
    output logic             goodRead,
    output logic             sleeping,
    output logic             detectProbe,
    output logic             illumOn,
    output logic             aimLedOn,
    output logic             pin3Out
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        tlc_cfg_type cfg;
        logic        pinStaged;
        tlc_num_type pend;
        logic [2:0]  digCnt;
        logic [13:0] acc;
        logic [13:0] rereadMs;
        logic [13:0] sleepSec;
        logic        trigPrev;
        logic        reading;
        logic        readStart;
        logic        goodRead;
        logic        holdActive;
        logic [13:0] holdMs;
        logic [15:0] msCnt;
        logic        msTick;
        logic [9:0]  secCnt;
        logic [13:0] idleSec;
        logic        sleeping;
        logic [6:0]  probeCnt;
        logic        probe;
        logic        altOn;
        logic        illumOn;
        logic        aimLedOn;
        logic        pin3Out;
    } tlc_state_type;

    tlc_state_type state_q;
    tlc_state_type state_d;

    logic        reqWr;
    logic        cmdWr;
    logic        digWr;
    logic [3:0]  digit;
    logic [16:0] accNext;
    logic        swTrig;
    logic        trigFall;
    logic        autoStart;
    logic        repeatGo;

    assign avs_waitrequest = (avs_read | avs_write) & ~state_q.ack;
    assign reqWr   = avs_write & state_q.ack & avs_byteenable[0];
    assign cmdWr   = reqWr & (avs_address == ADDR_CMD);
    assign digWr   = reqWr & (avs_address == ADDR_DIGIT);
    assign digit   = avs_writedata[3:0];
    assign accNext = 17'(state_q.acc) * 17'd10 + 17'(digit);
    assign swTrig  = cmdWr && (avs_writedata[7:0] == CMD_TRIGGER);
    assign trigFall = state_q.trigPrev & ~trigger_in_n;
    // Auto start is skipped while a read is running to avoid re-arming
    assign autoStart = state_q.cfg.autoOn & eng.objectDetect
                       & ~state_q.reading;
    assign repeatGo = state_q.reading & eng.readDone & ~trigger_in_n
                      & state_q.cfg.repeatOn & ~state_q.cfg.autoOn;

    always_comb begin
        state_d = state_q;
        state_d.ack = (avs_read | avs_write) & ~state_q.ack;
        state_d.trigPrev = trigger_in_n;
        state_d.msTick = 1'b0;
        state_d.probe = 1'b0;
        state_d.readStart = 1'b0;
        state_d.goodRead = 1'b0;

        // Register read path, latched on the same edge that drops waitrequest
        if (avs_read && !state_q.ack) begin
            unique case (avs_address)
                ADDR_CONFIG: state_d.rdata = 32'(state_q.cfg);
                ADDR_TIMES: begin
                    state_d.rdata = 32'h0000_0000;
                    state_d.rdata[13:0] = state_q.rereadMs;
                    state_d.rdata[TIMES_SLEEP_LSB +: 14] = state_q.sleepSec;
                end
                ADDR_STATUS: begin
                    state_d.rdata = 32'h0000_0000;
                    state_d.rdata[ST_SLEEPING] = state_q.sleeping;
                    state_d.rdata[ST_READING] = state_q.reading;
                    state_d.rdata[ST_HOLD] = state_q.holdActive;
                    state_d.rdata[ST_PEND_LSB +: 2] = state_q.pend;
                    state_d.rdata[ST_DIG_LSB +: 3] = state_q.digCnt;
                    state_d.rdata[ST_PIN_STAGED] = state_q.pinStaged;
                end
                default: state_d.rdata = 32'h0000_0000;
            endcase
        end

        // Command interpreter
        if (cmdWr) begin
            state_d.pend = NUM_NONE;
            state_d.digCnt = 3'h0;
            state_d.acc = 14'h0000;
            unique case (avs_writedata[7:0])
                CMD_REPEAT_OFF: state_d.cfg.repeatOn = 1'b0;
                CMD_REPEAT_ON: state_d.cfg.repeatOn = 1'b1;
                CMD_AUTO_OFF: state_d.cfg.autoOn = 1'b0;
                CMD_AUTO_ON: state_d.cfg.autoOn = 1'b1;
                CMD_PRESENT: state_d.cfg.handheld = 1'b0;
                CMD_HANDHELD: state_d.cfg.handheld = 1'b1;
                CMD_SENS_HIGH: state_d.cfg.sens = LVL_HIGH;
                CMD_SENS_NORMAL: state_d.cfg.sens = LVL_NORMAL;
                CMD_SENS_LOW: state_d.cfg.sens = LVL_LOW;
                CMD_REREAD: state_d.pend = NUM_REREAD;
                CMD_END_LONG: state_d.cfg.scanEnd = LVL_HIGH;
                CMD_END_NORMAL: state_d.cfg.scanEnd = LVL_NORMAL;
                CMD_END_SHORT: state_d.cfg.scanEnd = LVL_LOW;
                CMD_RTIME_AUTO: state_d.cfg.readAuto = 1'b1;
                CMD_RTIME_FIXED: state_d.cfg.readAuto = 1'b0;
                CMD_SLEEP_DELAY: state_d.pend = NUM_SLEEP;
                CMD_DET_AIM: state_d.cfg.detSrc = DET_AIM;
                CMD_DET_WARM: state_d.cfg.detSrc = DET_WARM;
                CMD_DET_UNLIT: state_d.cfg.detSrc = DET_UNLIT;
                CMD_ILLUM_ON: state_d.cfg.illumMode = ILL_ON;
                CMD_ILLUM_OFF: state_d.cfg.illumMode = ILL_OFF;
                CMD_ILLUM_ALT: state_d.cfg.illumMode = ILL_ALT;
                CMD_ILLUM_GLARE: state_d.cfg.illumMode = ILL_GLARE;
                CMD_ILLUM_STD: state_d.cfg.illumLow = 1'b0;
                CMD_ILLUM_LOW: state_d.cfg.illumLow = 1'b1;
                CMD_PIN_GOOD: state_d.pinStaged = 1'b0;
                CMD_PIN_EXT: state_d.pinStaged = 1'b1;
                CMD_SAVE: state_d.cfg.pinExtLight = state_q.pinStaged;
                CMD_AIM_ON: state_d.cfg.aimOn = 1'b1;
                CMD_AIM_OFF: state_d.cfg.aimOn = 1'b0;
                CMD_AIM_HIGH: state_d.cfg.aimLvl = LVL_HIGH;
                CMD_AIM_STD: state_d.cfg.aimLvl = LVL_NORMAL;
                CMD_AIM_LOW: state_d.cfg.aimLvl = LVL_LOW;
                CMD_CENTRAL_ON: state_d.cfg.central = 1'b1;
                CMD_CENTRAL_OFF: state_d.cfg.central = 1'b0;
                default: ;
            endcase
        end

        if (digWr && state_q.pend != NUM_NONE) begin
            if (digit > 4'h9) begin
                // A bad digit drops the whole entry, old value kept
                state_d.pend = NUM_NONE;
                state_d.digCnt = 3'h0;
            end else if (state_q.digCnt == 3'(NUM_DIGITS - 1)) begin
                state_d.pend = NUM_NONE;
                state_d.digCnt = 3'h0;
                if (state_q.pend == NUM_REREAD) begin
                    state_d.rereadMs = accNext[13:0];
                end else begin
                    state_d.sleepSec = accNext[13:0];
                end
            end else begin
                state_d.acc = accNext[13:0];
                state_d.digCnt = state_q.digCnt + 3'h1;
            end
        end

        // Millisecond and second timebase
        if (state_q.msCnt == 16'(MS_CYC - 1)) begin
            state_d.msCnt = 16'h0000;
            state_d.msTick = 1'b1;
        end else begin
            state_d.msCnt = state_q.msCnt + 16'h0001;
        end

        if (trigFall || swTrig || repeatGo ||
            (autoStart && !state_q.sleeping)) begin
            state_d.readStart = 1'b1;
            state_d.reading = 1'b1;
        end else if (eng.readDone) begin
            state_d.reading = 1'b0;
        end

        if (state_q.reading && eng.readDone && !eng.decodeValid) begin
            state_d.altOn = ~state_q.altOn;
        end

        // Hold-off runs down on ms ticks
        if (state_q.msTick && state_q.holdActive
            && state_q.rereadMs != 14'h0000) begin
            if (state_q.holdMs <= 14'h0001) begin
                state_d.holdActive = 1'b0;
            end else begin
                state_d.holdMs = state_q.holdMs - 14'h0001;
            end
        end
        if (eng.decodeValid) begin
            if (!state_q.cfg.autoOn) begin
                state_d.goodRead = 1'b1;
                state_d.holdActive = 1'b0;
            end else if (!(state_q.holdActive && eng.decodeSame)) begin
                state_d.goodRead = 1'b1;
                state_d.holdActive = 1'b1;
                state_d.holdMs = state_q.rereadMs;
            end
        end

        if (!state_q.cfg.autoOn || eng.objectDetect || state_q.sleeping) begin
            state_d.idleSec = 14'h0000;
            state_d.secCnt = 10'h000;
        end else if (state_q.msTick) begin
            if (state_q.secCnt == 10'(SEC_MS - 1)) begin
                state_d.secCnt = 10'h000;
                state_d.idleSec = state_q.idleSec + 14'h0001;
            end else begin
                state_d.secCnt = state_q.secCnt + 10'h001;
            end
        end
        if (state_q.cfg.autoOn && !state_q.sleeping
            && state_q.sleepSec != 14'h0000
            && state_q.idleSec >= state_q.sleepSec) begin
            state_d.sleeping = 1'b1;
        end
        // Probe while asleep, wake on detect or trigger
        if (state_q.sleeping) begin
            if (eng.objectDetect || !trigger_in_n || !state_q.cfg.autoOn) begin
                state_d.sleeping = 1'b0;
                state_d.probeCnt = 7'h00;
            end else if (state_q.msTick) begin
                if (state_q.probeCnt == 7'(PROBE_MS - 1)) begin
                    state_d.probeCnt = 7'h00;
                    state_d.probe = 1'b1;
                end else begin
                    state_d.probeCnt = state_q.probeCnt + 7'h01;
                end
            end
        end

        unique case (state_q.cfg.illumMode)
            ILL_ON: state_d.illumOn = state_q.reading;
            ILL_OFF: state_d.illumOn = 1'b0;
            ILL_ALT: state_d.illumOn = state_q.reading & state_q.altOn;
            ILL_GLARE: state_d.illumOn = state_q.reading & ~eng.specular;
        endcase
        state_d.aimLedOn = state_q.cfg.aimOn & (state_q.reading |
            (state_q.cfg.autoOn & ~state_q.sleeping
             & state_q.cfg.detSrc == DET_AIM));
        // One pin function at a time
        state_d.pin3Out = state_q.cfg.pinExtLight ? state_d.illumOn
                                                  : state_d.goodRead;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
            state_q.cfg <= CFG_RESET;
            state_q.rereadMs <= RST_REREAD_MS;
            state_q.sleepSec <= RST_SLEEP_S;
            state_q.trigPrev <= 1'b1;
            state_q.altOn <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign avs_readdata = state_q.rdata;
    assign cfg          = state_q.cfg;
    assign readStart    = state_q.readStart;
    assign goodRead     = state_q.goodRead;
    assign sleeping     = state_q.sleeping;
    assign detectProbe  = state_q.probe;
    assign illumOn      = state_q.illumOn;
    assign aimLedOn     = state_q.aimLedOn;
    assign pin3Out      = state_q.pin3Out;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_trig_fall;
        $fell(trigger_in_n) ##0 !state_q.sleeping;
    endsequence

    property p_trig_start;
        s_trig_fall |=> readStart;
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("trigger fall did not start a read");

    property p_repeat_manual;
        readStart && $past(eng.readDone) && $past(state_q.reading)
        && !$past(swTrig) && !$past(trigFall) && !$past(autoStart)
        |-> $past(state_q.cfg.repeatOn) && !$past(state_q.cfg.autoOn);
    endproperty
    a_repeat_manual: assert property (p_repeat_manual)
        else $error("repeat restart outside manual repeat mode");

    property p_auto_start;
        cfg.autoOn && eng.objectDetect && !state_q.reading && !sleeping
        |=> readStart;
    endproperty
    a_auto_start: assert property (p_auto_start)
        else $error("auto detection did not start a read");

    property p_hold_suppress;
        cfg.autoOn && state_q.holdActive && eng.decodeValid
        && eng.decodeSame |=> !goodRead;
    endproperty
    a_hold_suppress: assert property (p_hold_suppress)
        else $error("identical data passed during hold-off");

    property p_diff_cancel;
        cfg.autoOn && eng.decodeValid && !eng.decodeSame
        |=> goodRead ##0 state_q.holdMs == $past(state_q.rereadMs);
    endproperty
    a_diff_cancel: assert property (p_diff_cancel)
        else $error("different data did not restart hold-off");

    property p_zero_hold;
        state_q.holdActive && state_q.rereadMs == 14'h0000
        && !eng.decodeValid && !cmdWr && !digWr |=> state_q.holdActive;
    endproperty
    a_zero_hold: assert property (p_zero_hold)
        else $error("zero interval hold-off expired");

    property p_zero_sleep;
        $rose(sleeping) |-> $past(state_q.sleepSec) != 14'h0000;
    endproperty
    a_zero_sleep: assert property (p_zero_sleep)
        else $error("sleep entered with zero sleep time");

    property p_wake;
        sleeping && (!trigger_in_n || eng.objectDetect) |=> !sleeping;
    endproperty
    a_wake: assert property (p_wake)
        else $error("did not wake on trigger or detection");

    property p_glare;
        cfg.illumMode == ILL_GLARE && eng.specular |=> !illumOn;
    endproperty
    a_glare: assert property (p_glare)
        else $error("illumination on during specular reflection");

    property p_pin_good;
        !cfg.pinExtLight && $past(!cfg.pinExtLight) |-> pin3Out == goodRead;
    endproperty
    a_pin_good: assert property (p_pin_good)
        else $error("shared pin not following good read");

    property p_pin_save;
        $changed(cfg.pinExtLight) |-> $past(cmdWr)
        && $past(avs_writedata[7:0]) == CMD_SAVE;
    endproperty
    a_pin_save: assert property (p_pin_save)
        else $error("pin function changed without save");

endmodule : tlc_core

// ---- test/tlc_eng_model.sv ----
`timescale 1ns/1ps
// Stand-in imaging engine; each read ends DLY cycles after it starts
module tlc_eng_model
    import tlc_pkg::*;
#(
    parameter int DLY = 6
) (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   readStart,
    input  wire logic   decOk,
    input  wire logic   sameData,
    input  wire logic   objIn,
    input  wire logic   glare,
    output tlc_eng_type eng
);
    int cnt;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
        end else if (readStart) begin
            cnt <= DLY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Same-data flag is inverted outside decodes, so stale sampling shows up
    always_comb begin
        eng.objectDetect = objIn;
        eng.specular     = glare;
        eng.readDone     = (cnt == 1);
        eng.decodeValid  = (cnt == 1) && decOk;
        eng.decodeSame   = (cnt == 1) ? sameData : !sameData;
    end
endmodule : tlc_eng_model

// ---- test/tlc_core_tb.sv ----
`timescale 1ns/1ps
module tlc_core_tb;
    import tlc_pkg::*;
    logic        sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [4:0]  avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic        avs_waitrequest, trigger_in_n = 1;
    logic        decOk = 1, sameData = 0, objIn = 0, glare = 0;
    logic        readStart, goodRead, sleeping, detectProbe;
    logic        illumOn, aimLedOn, pin3Out;
    tlc_eng_type eng;
    tlc_cfg_type cfg, e;
    int          n_errors = 0, n_tests = 0, nGood = 0, nPin = 0, cyc = 0, n;
    int          nPr = 0;
    tlc_core #(.MS_CYC(5)) tlc_core_i (.sys_clk(sys_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trigger_in_n(trigger_in_n),
        .eng(eng), .cfg(cfg), .readStart(readStart), .goodRead(goodRead),
        .sleeping(sleeping), .detectProbe(detectProbe), .illumOn(illumOn),
        .aimLedOn(aimLedOn), .pin3Out(pin3Out));
    tlc_eng_model tlc_eng_model_i (.sys_clk(sys_clk), .rst(rst),
        .readStart(readStart), .decOk(decOk), .sameData(sameData),
        .objIn(objIn), .glare(glare), .eng(eng));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        nGood <= nGood + (goodRead === 1'b1);
        nPin <= nPin + (pin3Out === 1'b1);
        nPr <= nPr + (detectProbe === 1'b1);
        if (cyc == 40000) begin
            $display("unexpected at %0t: timeout", $time);
            n_errors = n_errors + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask : acc
    task automatic rdc(input logic [4:0] a, input logic [31:0] x);
        acc(0, a, '0);
        chk(q, x);
    endtask : rdc
    task automatic cmdc(input tlc_cmd_type c);
        acc(1, ADDR_CMD, 32'(c));
        rdc(ADDR_CONFIG, 32'(e));
        chk(32'(cfg), 32'(e));
    endtask : cmdc
    task automatic num(input tlc_cmd_type c, input int v);
        acc(1, ADDR_CMD, 32'(c));
        for (int i = 1000; i > 0; i = i / 10) acc(1, ADDR_DIGIT, (v / i) % 10);
    endtask : num
    task automatic rdone();
        while (eng.readDone !== 1'b1) begin
            @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
    endtask : rdone
    task automatic det(input logic s);
        sameData <= s;
        objIn <= 1;
        @(posedge sys_clk);
        objIn <= 0;
        rdone();
    endtask : det
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        e = CFG_RESET;
        rdc(ADDR_CONFIG, 32'(e));
        rdc(ADDR_TIMES, 32'h0005_02BC);
        rdc(5'h14, 32'h0000_0000);
        trigger_in_n <= 0;
        rdone();
        trigger_in_n <= 1;
        chk(nGood, 1);
        chk(nPin, 1);
        glare <= 1;
        acc(1, ADDR_CMD, 32'(CMD_TRIGGER));
        repeat (2) @(posedge sys_clk);
        chk(illumOn, 0);
        chk(aimLedOn, 1);
        glare <= 0;
        repeat (2) @(posedge sys_clk);
        chk(illumOn, 1);
        rdone();
        chk(nGood, 2);
        e.repeatOn = 1;
        cmdc(CMD_REPEAT_ON);
        trigger_in_n <= 0;
        rdone();
        rdone();
        trigger_in_n <= 1;
        rdone();
        chk(nGood, 5);
        e.handheld = 1;
        cmdc(CMD_HANDHELD);
        e.sens = LVL_LOW;
        cmdc(CMD_SENS_LOW);
        e.scanEnd = LVL_LOW;
        cmdc(CMD_END_SHORT);
        e.illumMode = ILL_ALT;
        cmdc(CMD_ILLUM_ALT);
        e.aimOn = 0;
        cmdc(CMD_AIM_OFF);
        e.sens = LVL_HIGH;
        cmdc(CMD_SENS_HIGH);
        e.scanEnd = LVL_HIGH;
        cmdc(CMD_END_LONG);
        e.readAuto = 1;
        cmdc(CMD_RTIME_AUTO);
        e.central = 1;
        cmdc(CMD_CENTRAL_ON);
        e.illumLow = 1;
        cmdc(CMD_ILLUM_LOW);
        e.aimLvl = LVL_NORMAL;
        cmdc(CMD_AIM_STD);
        e.repeatOn = 0;
        cmdc(CMD_REPEAT_OFF);
        num(CMD_REREAD, 12);
        rdc(ADDR_TIMES, 32'h0005_000C);
        e.autoOn = 1;
        cmdc(CMD_AUTO_ON);
        chk(aimLedOn, 0);
        e.detSrc = DET_WARM;
        cmdc(CMD_DET_WARM);
        det(0);
        det(1);
        chk(nGood, 6);
        det(0);
        chk(nGood, 7);
        repeat (100) @(posedge sys_clk);
        det(1);
        chk(nGood, 8);
        num(CMD_REREAD, 0);
        det(0);
        repeat (100) @(posedge sys_clk);
        det(1);
        chk(nGood, 9);
        num(CMD_SLEEP_DELAY, 1);
        for (n = 0; n < 6000 && sleeping !== 1'b1; n++) @(posedge sys_clk);
        chk(sleeping, 1);
        chk(n > 4900, 1);
        repeat (1100) @(posedge sys_clk);
        chk(nPr, 2);
        trigger_in_n <= 0;
        repeat (4) @(posedge sys_clk);
        chk(sleeping, 0);
        trigger_in_n <= 1;
        num(CMD_SLEEP_DELAY, 0);
        repeat (5500) @(posedge sys_clk);
        chk(sleeping, 0);
        acc(1, ADDR_CMD, 32'(CMD_PIN_EXT));
        rdc(ADDR_CONFIG, 32'(e));
        e.pinExtLight = 1;
        cmdc(CMD_SAVE);
        acc(1, ADDR_CMD, 32'(CMD_TRIGGER));
        repeat (2) @(posedge sys_clk);
        chk(pin3Out, 1);
        rdone();
        decOk <= 0;
        acc(1, ADDR_CMD, 32'(CMD_TRIGGER));
        rdone();
        decOk <= 1;
        acc(1, ADDR_CMD, 32'(CMD_TRIGGER));
        repeat (2) @(posedge sys_clk);
        chk(illumOn, 0);
        finish_test();
    end
endmodule : tlc_core_tb
